// File: hdl/system_reset_sequencer.sv
// Purpose: System reset sequencer with Avalon-MM register access.
// Assumes: All pin inputs are synchronous to sys_clk; rst_n is the power-on reset.
// Notes:   Pin filtering is a digital stand-in for the analog filter.
//
// Summary of operation
// - Low request with mode pin high: warm reset.
// - Warm reset tri-states I/O, drives reset output.
// - Settle window cancels holds, aborts bus cycle.
// - Pull-down only if bidir enable set; clear it.
// - Internal sequence starts early, lasts 1024 units.
// - Sample filtered input after 8 units: short/long.
// - Long reset opens config bits 15..13 briefly.
// - Extend until input high, then flash wait if internal.
// - Exit latches config, idles strobes, fetch zero.
// - Mode pin low converts to asynchronous reset.
// - Software/watchdog resets ignore the mode pin except for bidir pull.
// - Mode pin gated by filtered input only.
// - Software reset: short sequence, partial config latch.
// - Software bidir pull only while mode pin high.
// - Watchdog overflow starts the reset sequence.
// - Watchdog completes or aborts running bus cycle.
// - Watchdog end latches bits 12..8, sets 7..2.
// - Watchdog bidir pull only while mode pin high.
// - Async release restarts, after flash if internal.
// - Async reset: output low, abort, tri-state, pull-up.
// - Bidir enable is config bit 3, init only.
// - Reset cause flags readable by software.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
module system_reset_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reset_request_pin_n_i,
  output logic             reset_request_pin_n_o,
  output logic             reset_request_pin_n_oe_n,
  input  wire logic        reset_mode_cap_pin,
  input  wire logic        external_boot_select_n,
  input  wire logic        flash_ready,
  input  wire logic [15:0] config_port_zero_i,
  input  wire logic        software_reset_instruction,
  input  wire logic        watchdog_overflow,
  input  wire logic        end_of_init_instruction,
  input  wire logic        ext_cycle_active,
  input  wire logic        ext_cycle_uses_ready,
  input  wire logic        wait_states_done,
  input  wire logic        ready_n,
  output logic             reset_output_pin_n,
  output logic             internal_reset_n,
  output logic             io_tristate,
  output logic             hold_cancel,
  output logic             bus_abort,
  output logic             port0_pullup,
  output logic             clock_option_transparent,
  output logic             bus_strobes_idle,
  output logic [15:0]      latched_config,
  output logic [23:0]      fetch_address,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  reset_seq_pkg::seq_state_e  state_q,  state_d;
  reset_seq_pkg::reset_kind_e kind_q,   kind_d;
  logic [9:0]  cnt_q, cnt_d;
  logic [1:0]  filt_q;
  logic        filtered_reset_input_q;
  logic        bidir_en_q;
  logic        bdr_act_q;
  logic        init_open_q;
  logic        reset_output_pin_n_n_q;
  logic        transp_q;
  logic [4:0]  flags_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [15:0] cfg_q;
  logic [23:0] fetch_q;

  // Input filter: the filtered level only moves after a stable run of samples.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 2'b00;
      filtered_reset_input_q <= 1'b0;
    end else begin
      filt_q <= {filt_q[0], reset_request_pin_n_i};
      if (filt_q == 2'b00) begin
        filtered_reset_input_q <= 1'b0;
      end else if (filt_q == 2'b11) begin
        filtered_reset_input_q <= 1'b1;
      end
    end
  end

  wire in_run      = (state_q == reset_seq_pkg::ST_RUN);
  wire in_settle   = (state_q == reset_seq_pkg::ST_SETTLE);
  wire in_seq      = (state_q == reset_seq_pkg::ST_SEQ);
  wire in_post     = (state_q == reset_seq_pkg::ST_POST);
  wire in_extend   = (state_q == reset_seq_pkg::ST_EXTEND);
  wire in_flashw   = (state_q == reset_seq_pkg::ST_FLASHW);
  wire in_async    = (state_q == reset_seq_pkg::ST_ASYNC);
  wire kind_hw     = (kind_q == reset_seq_pkg::KIND_HW);
  wire kind_sw     = (kind_q == reset_seq_pkg::KIND_SW);
  wire kind_wdt    = (kind_q == reset_seq_pkg::KIND_WDT);
  wire internal_boot = external_boot_select_n;

  wire hw_req      = in_run && !filtered_reset_input_q && reset_mode_cap_pin;
  wire async_req   = !filtered_reset_input_q && !reset_mode_cap_pin;
  wire async_conv  = async_req && kind_hw && (in_settle || in_seq || in_extend);
  wire wdt_abort   = ext_cycle_active && ext_cycle_uses_ready && wait_states_done
                     && ready_n;
  wire wdt_bus_ok  = !ext_cycle_active || wdt_abort;
  wire settle_go   = (cnt_q == reset_seq_pkg::SETTLE_LAST) && (!kind_wdt || wdt_bus_ok);
  wire seq_done    = in_seq && (cnt_q == reset_seq_pkg::SEQ_LAST);
  wire post_done   = in_post && (cnt_q == reset_seq_pkg::POST_LAST);
  wire exit_now    = (state_d == reset_seq_pkg::ST_RUN) && !in_run;
  wire transp_end  = in_extend && filtered_reset_input_q && (cnt_q == reset_seq_pkg::TRANSP_LAST);

  // Sequencer next state.
  always_comb begin
    state_d = state_q;
    kind_d  = kind_q;
    cnt_d   = cnt_q + 10'h001;
    case (state_q)
      reset_seq_pkg::ST_RUN: begin
        if (async_req) begin
          state_d = reset_seq_pkg::ST_ASYNC;
          kind_d  = reset_seq_pkg::KIND_ASYNC;
        end else if (hw_req) begin
          state_d = reset_seq_pkg::ST_SETTLE;
          kind_d  = reset_seq_pkg::KIND_HW;
        end else if (watchdog_overflow) begin
          state_d = reset_seq_pkg::ST_SETTLE;
          kind_d  = reset_seq_pkg::KIND_WDT;
        end else if (software_reset_instruction) begin
          state_d = reset_seq_pkg::ST_SETTLE;
          kind_d  = reset_seq_pkg::KIND_SW;
        end
      end
      reset_seq_pkg::ST_SETTLE: begin
        if (async_conv) begin
          state_d = reset_seq_pkg::ST_ASYNC;
          kind_d  = reset_seq_pkg::KIND_ASYNC;
        end else if (settle_go) begin
          state_d = reset_seq_pkg::ST_SEQ;
        end else if (cnt_q == reset_seq_pkg::SETTLE_LAST) begin
          cnt_d = cnt_q;
        end
      end
      reset_seq_pkg::ST_SEQ: begin
        if (async_conv) begin
          state_d = reset_seq_pkg::ST_ASYNC;
          kind_d  = reset_seq_pkg::KIND_ASYNC;
        end else if (seq_done) begin
          state_d = reset_seq_pkg::ST_POST;
        end
      end
      reset_seq_pkg::ST_POST: begin
        if (post_done) begin
          if (!filtered_reset_input_q) begin
            state_d = reset_seq_pkg::ST_EXTEND;
            kind_d  = reset_seq_pkg::KIND_HW;
          end else if (internal_boot) begin
            state_d = reset_seq_pkg::ST_FLASHW;
          end else begin
            state_d = reset_seq_pkg::ST_RUN;
          end
        end
      end
      reset_seq_pkg::ST_EXTEND: begin
        if (async_conv) begin
          state_d = reset_seq_pkg::ST_ASYNC;
          kind_d  = reset_seq_pkg::KIND_ASYNC;
        end else if (!filtered_reset_input_q) begin
          cnt_d = 10'h000;
        end else if (transp_end) begin
          state_d = internal_boot ? reset_seq_pkg::ST_FLASHW : reset_seq_pkg::ST_RUN;
        end
      end
      reset_seq_pkg::ST_FLASHW: begin
        if (flash_ready) begin
          state_d = reset_seq_pkg::ST_RUN;
        end
      end
      reset_seq_pkg::ST_ASYNC: begin
        if (filtered_reset_input_q) begin
          state_d = internal_boot ? reset_seq_pkg::ST_FLASHW : reset_seq_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = reset_seq_pkg::ST_ASYNC;
        kind_d  = reset_seq_pkg::KIND_ASYNC;
      end
    endcase
    if (state_d != state_q) begin
      cnt_d = 10'h000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= reset_seq_pkg::ST_ASYNC;
      kind_q  <= reset_seq_pkg::KIND_ASYNC;
      cnt_q   <= 10'h000;
    end else begin
      state_q <= state_d;
      kind_q  <= kind_d;
      cnt_q   <= cnt_d;
    end
  end

  // Bidirectional pull-down: armed from the enable at reset start, enable then cleared.
  wire start_sync  = in_run && (state_d == reset_seq_pkg::ST_SETTLE);
  wire start_any   = in_run && !(state_d == reset_seq_pkg::ST_RUN);
  wire pull_phase  = in_settle || in_seq;
  wire pull_low    = bdr_act_q && pull_phase && (kind_hw || reset_mode_cap_pin);

  // Register bus decode.
  wire bus_req     = avs_read || avs_write;
  wire sel_syscfg  = (avs_address == reset_seq_pkg::OFS_SYSCFG);
  wire sel_wdtctl  = (avs_address == reset_seq_pkg::OFS_WDTCTL);
  wire sel_status  = (avs_address == reset_seq_pkg::OFS_STATUS);
  wire wr_take     = avs_write && ack_q && avs_byteenable[0];
  wire wr_syscfg   = wr_take && sel_syscfg && init_open_q && in_run;
  wire wr_wdtctl   = wr_take && sel_wdtctl;
  wire [31:0] rd_mux = sel_syscfg ? {28'h000_0000, bidir_en_q, 3'h0} :
                       sel_wdtctl ? {27'h000_0000, flags_q} :
                       sel_status ? {cfg_q, 8'h00, reset_output_pin_n_n_q, transp_q, kind_q, 1'b0, state_q} :
                       32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bidir_en_q  <= 1'b0;
      bdr_act_q   <= 1'b0;
      init_open_q <= 1'b0;
      reset_output_pin_n_n_q  <= 1'b0;
    end else begin
      if (start_any || !in_run) begin
        bidir_en_q <= 1'b0;
      end else if (wr_syscfg) begin
        bidir_en_q <= avs_writedata[reset_seq_pkg::BIDIR_BIT];
      end
      if (start_sync) begin
        bdr_act_q <= bidir_en_q;
      end else if (in_run) begin
        bdr_act_q <= 1'b0;
      end
      if (exit_now) begin
        init_open_q <= 1'b1;
      end else if (end_of_init_instruction || !in_run) begin
        init_open_q <= exit_now;
      end
      if (start_any || !in_run) begin
        reset_output_pin_n_n_q <= 1'b0;
      end else if (end_of_init_instruction) begin
        reset_output_pin_n_n_q <= 1'b1;
      end
    end
  end

  // Reset cause flags; a set in the same cycle as a clear wins.
  logic [4:0] flag_set;
  always_comb begin
    flag_set = 5'h00;
    if (in_async && filtered_reset_input_q) begin
      flag_set[reset_seq_pkg::FLG_ASYNC] = 1'b1;
    end
    if (post_done) begin
      if (!filtered_reset_input_q) begin
        flag_set[reset_seq_pkg::FLG_SHORT] = 1'b1;
        flag_set[reset_seq_pkg::FLG_LONG]  = kind_hw;
      end else begin
        flag_set[reset_seq_pkg::FLG_SHORT] = kind_hw;
        flag_set[reset_seq_pkg::FLG_SW]    = kind_sw;
        flag_set[reset_seq_pkg::FLG_WDT]   = kind_wdt;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= reset_seq_pkg::FLAGS_RST;
    end else if (start_any) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= (flags_q & ~(wr_wdtctl ? avs_writedata[4:0] : 5'h00)) | flag_set;
    end
  end

  // Clock-option transparency and configuration latch.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transp_q <= 1'b0;
      cfg_q    <= reset_seq_pkg::CFG_RST;
      fetch_q  <= reset_seq_pkg::FETCH_START;
    end else begin
      if (post_done && !filtered_reset_input_q && kind_hw) begin
        transp_q <= 1'b1;
      end else if (transp_end || !in_extend) begin
        transp_q <= 1'b0;
      end
      if (transp_q) begin
        cfg_q[15:13] <= config_port_zero_i[15:13];
      end
      if (exit_now) begin
        fetch_q <= reset_seq_pkg::FETCH_START;
        if (kind_sw || kind_wdt) begin
          cfg_q[12:8] <= config_port_zero_i[12:8];
          cfg_q[7:2]  <= reset_seq_pkg::CFG_FORCED_ONE;
        end else begin
          cfg_q <= config_port_zero_i;
        end
      end
    end
  end

  // Avalon-MM slave: one wait cycle, read data registered for the release edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req && !ack_q;
      if (avs_read && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign avs_waitrequest          = bus_req && !ack_q;
  assign avs_readdata             = rdata_q;
  assign reset_request_pin_n_o    = 1'b0;
  assign reset_request_pin_n_oe_n = !pull_low;
  assign reset_output_pin_n       = reset_output_pin_n_n_q;
  assign internal_reset_n         = in_run;
  assign io_tristate              = !in_run;
  assign hold_cancel              = in_settle || in_async;
  assign bus_abort                = in_async || (in_settle && !kind_wdt)
                                    || (in_settle && kind_wdt && wdt_abort);
  assign port0_pullup             = in_async;
  assign clock_option_transparent = transp_q;
  assign bus_strobes_idle         = !in_run;
  assign latched_config           = cfg_q;
  assign fetch_address            = fetch_q;

  // Checks.
  chk_out_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !in_run |-> !reset_output_pin_n)
    else $error("Reset output high during reset.");
  chk_start_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hw_req && !async_req |-> ##[1:8] (in_seq || in_async))
    else $error("Sequence did not start in time.");
  chk_seq_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_seq && !async_conv && (cnt_q != reset_seq_pkg::SEQ_LAST) |=>
    in_seq && (cnt_q == $past(cnt_q) + 10'h001))
    else $error("Sequence ended early.");
  chk_seq_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_seq && (state_d == reset_seq_pkg::ST_POST) |-> cnt_q == reset_seq_pkg::SEQ_LAST)
    else $error("Sequence length wrong.");
  chk_post_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(in_post) |-> in_post [*4] ##1 !in_post)
    else $error("Sample delay wrong.");
  chk_async_conv: assert property (@(posedge sys_clk) disable iff (!rst_n)
    kind_hw && (in_settle || in_seq) && async_req |=> in_async)
    else $error("Missed asynchronous conversion.");
  chk_sw_mode_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (kind_sw || kind_wdt) && (in_settle || in_seq) |=> !in_async)
    else $error("Software reset converted.");
  chk_bidir_pull: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (kind_sw || kind_wdt) && !reset_mode_cap_pin |-> reset_request_pin_n_oe_n)
    else $error("Pull-down active with mode pin low.");
  chk_bidir_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_settle |-> !bidir_en_q)
    else $error("Bidir enable survived reset.");
  chk_transp_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_extend && $rose(filtered_reset_input_q) && transp_q |-> transp_q ##2 !transp_q)
    else $error("Transparency end wrong.");
  chk_flash_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_flashw && !flash_ready |=> !internal_reset_n)
    else $error("Released before flash ready.");
  chk_sw_config: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(internal_reset_n) && (kind_sw || kind_wdt) |->
    latched_config[7:2] == reset_seq_pkg::CFG_FORCED_ONE &&
    fetch_address == reset_seq_pkg::FETCH_START)
    else $error("Partial config latch wrong.");

  cov_long: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(transp_q));
  cov_async: cover property (@(posedge sys_clk) disable iff (!rst_n) async_conv);
  cov_wdt_abort: cover property (@(posedge sys_clk) disable iff (!rst_n)
    in_settle && kind_wdt && wdt_abort);
  cov_sw_exit: cover property (@(posedge sys_clk) disable iff (!rst_n)
    exit_now && kind_sw);

endmodule : system_reset_sequencer

// File: include/reset_seq_pkg.sv
// Purpose: Shared constants and types of the system reset sequencer.
// Assumes: The CPU clock equals sys_clk, so one half_clock_unit is half a sys_clk period.
// Notes:   Times are held in half_clock_unit and converted to sys_clk cycles here.
package reset_seq_pkg;

  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned TCL_PER_CYCLE  = 2;

  // Times in half_clock_unit and their cycle counts (least rounds up, longest rounds down).
  localparam int unsigned FILTER_TCL     = 4;
  localparam int unsigned FILTER_CYC     = (FILTER_TCL + TCL_PER_CYCLE - 1) / TCL_PER_CYCLE;
  localparam int unsigned SETTLE_TCL     = 12;
  localparam int unsigned SETTLE_CYC     = SETTLE_TCL / TCL_PER_CYCLE;
  localparam int unsigned START_TCL      = 16;
  localparam int unsigned START_CYC      = START_TCL / TCL_PER_CYCLE;
  localparam int unsigned SEQ_TCL        = 1024;
  localparam int unsigned SEQ_CYC        = SEQ_TCL / TCL_PER_CYCLE;
  localparam int unsigned POST_TCL       = 8;
  localparam int unsigned POST_CYC       = POST_TCL / TCL_PER_CYCLE;
  localparam int unsigned TRANSP_TCL     = 4;
  localparam int unsigned TRANSP_CYC     = TRANSP_TCL / TCL_PER_CYCLE;

  localparam logic [9:0]  SETTLE_LAST    = 10'(SETTLE_CYC - 1);
  localparam logic [9:0]  SEQ_LAST       = 10'(SEQ_CYC - 1);
  localparam logic [9:0]  POST_LAST      = 10'(POST_CYC - 1);
  localparam logic [9:0]  TRANSP_LAST    = 10'(TRANSP_CYC - 1);

  // Register byte offsets.
  localparam logic [3:0]  OFS_SYSCFG     = 4'h0;
  localparam logic [3:0]  OFS_WDTCTL     = 4'h4;
  localparam logic [3:0]  OFS_STATUS     = 4'h8;

  // Field positions.
  localparam int unsigned BIDIR_BIT      = 3;
  localparam int unsigned FLG_ASYNC      = 0;
  localparam int unsigned FLG_SW         = 1;
  localparam int unsigned FLG_WDT        = 2;
  localparam int unsigned FLG_SHORT      = 3;
  localparam int unsigned FLG_LONG       = 4;
  localparam int unsigned FLG_W          = 5;

  // Reset values.
  localparam logic [4:0]  FLAGS_RST      = 5'h01;
  localparam logic [15:0] CFG_RST        = 16'hffff;
  localparam logic [23:0] FETCH_START    = 24'h00_0000;
  localparam logic [5:0]  CFG_FORCED_ONE = 6'h3f;

  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_RUN    = 3'h0,
    ST_SETTLE = 3'h1,
    ST_SEQ    = 3'h3,
    ST_POST   = 3'h2,
    ST_EXTEND = 3'h6,
    ST_FLASHW = 3'h7,
    ST_ASYNC  = 3'h4
  } seq_state_e;

  typedef enum logic [1:0] {
    KIND_HW    = 2'h0,
    KIND_SW    = 2'h1,
    KIND_WDT   = 2'h2,
    KIND_ASYNC = 2'h3
  } reset_kind_e;

endpackage : reset_seq_pkg

// File: tb/reset_board_model.sv
// Purpose: Board reset source and reset mode capacitor beside the sequencer.
// Assumes: The reset request line has a pull-up; start loads a low pulse length.
// Notes:   The device's open-drain pull joins the board pulse on one wire.
module reset_board_model (
  input  wire logic       sys_clk,
  input  wire logic       start,
  input  wire logic [9:0] len,
  input  wire logic       mode_low,
  input  wire logic       drv,
  input  wire logic       oe_n,
  output logic            pin_n,
  output logic            mode_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] left_q = 10'h000;
  always @(posedge sys_clk) begin
    if (start)
      left_q <= (len < 10'h002) ? 10'h002 : len;
    else if (left_q != 10'h000)
      left_q <= left_q - 10'h001;
  end
  assign pin_n = !((left_q != 10'h000) || (!oe_n && !drv));
  assign mode_pin = !mode_low;
endmodule : reset_board_model

// File: tb/test_system_reset_sequencer.sv
// Purpose: Self-checking bench of the system reset sequencer.
// Assumes: External boot until the last test selects flash boot.
// Notes:   Rows run hw, sw and watchdog resets; long, async and flash cases follow.
module test_system_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [1:0] k; logic b; logic m; logic [15:0] c; logic [31:0] f; logic o;} row_s;
  logic        sys_clk = 0, rst_n = 0, start = 0, mode_low = 0, sw = 0, wd = 0, eoi = 0;
  logic        boot_n = 0, fl_rdy = 0, rd = 0, wr = 0, xact = 0, xrdy = 0;
  logic [9:0]  len = 10'h003;
  logic [15:0] cfg = 16'h1234, ecfg, lcfg;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic [23:0] fa;
  logic        pin_n, mode_pin, drv, oe_n, rout_n, irst_n, tri_s, hc, ab, pu, tr, idl, wreq;
  int          fails = 0, tests_run = 0, n;
  bit          oe_seen, tr_seen, hc_seen, ab_seen, bad;
  row_s        rows [6];
  always #20 sys_clk = ~sys_clk;
  reset_board_model brd (.sys_clk(sys_clk), .start(start), .len(len), .mode_low(mode_low),
    .drv(drv), .oe_n(oe_n), .pin_n(pin_n), .mode_pin(mode_pin));
  system_reset_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .reset_request_pin_n_i(pin_n),
    .reset_request_pin_n_o(drv), .reset_request_pin_n_oe_n(oe_n), .reset_mode_cap_pin(mode_pin),
    .external_boot_select_n(boot_n), .flash_ready(fl_rdy), .config_port_zero_i(cfg),
    .software_reset_instruction(sw), .watchdog_overflow(wd), .end_of_init_instruction(eoi),
    .ext_cycle_active(xact), .ext_cycle_uses_ready(xrdy), .wait_states_done(xrdy),
    .ready_n(xact), .reset_output_pin_n(rout_n), .internal_reset_n(irst_n), .io_tristate(tri_s),
    .hold_cancel(hc), .bus_abort(ab), .port0_pullup(pu), .clock_option_transparent(tr),
    .bus_strobes_idle(idl), .latched_config(lcfg), .fetch_address(fa), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wreq));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wdat <= d;
    do @(posedge sys_clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task wait_rst;
    n = 0;
    {oe_seen, tr_seen, hc_seen, ab_seen, bad} = 5'h00;
    repeat (2000) begin
      @(posedge sys_clk);
      if (irst_n === 1'b1 && n > 0) break;
      if (irst_n !== 1'b1) n++;
      oe_seen |= !oe_n;
      tr_seen |= tr;
      hc_seen |= hc;
      ab_seen |= ab;
      bad |= (irst_n !== 1'b1) && !(tri_s && idl);
    end
    chk(irst_n, 1'b1);
  endtask : wait_rst
  task pulse_start(input logic [9:0] l);
    len <= l;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask : pulse_start
  task end_init;
    eoi <= 1'b1;
    @(posedge sys_clk);
    eoi <= 1'b0;
    @(posedge sys_clk);
    chk(rout_n, 1'b1);
  endtask : end_init
  task report_and_stop;
    $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #(40 * 20000);
    fails++;
    report_and_stop();
  end
  initial begin
    rows[0] = '{2'h0, 1'b0, 1'b0, 16'habcd, 32'h0000_0008, 1'b0};
    rows[1] = '{2'h1, 1'b1, 1'b0, 16'h5a5a, 32'h0000_0002, 1'b1};
    rows[2] = '{2'h1, 1'b1, 1'b1, 16'h0f0f, 32'h0000_0002, 1'b0};
    rows[3] = '{2'h2, 1'b1, 1'b0, 16'hf0f0, 32'h0000_0004, 1'b1};
    rows[4] = '{2'h2, 1'b0, 1'b1, 16'h3c3c, 32'h0000_0004, 1'b0};
    rows[5] = '{2'h0, 1'b1, 1'b0, 16'hc3c3, 32'h0000_0008, 1'b1};
    repeat (4) @(posedge sys_clk);
    chk({irst_n, rout_n, pu}, 3'b001);
    rst_n <= 1'b1;
    wait_rst();
    ecfg = cfg;
    chk({lcfg, fa}, {cfg, 24'h00_0000});
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    $display("Power-on test done");
    foreach (rows[i]) begin
      if (rows[i].b)
        bus(1'b1, 4'h0, 32'h0000_0008);
      bus(1'b0, 4'h0, 32'h0000_0000);
      chk(q, {rows[i].b, 3'h0});
      end_init();
      cfg <= rows[i].c;
      mode_low <= rows[i].m;
      sw <= rows[i].k == 2'h1;
      wd <= rows[i].k == 2'h2;
      if (rows[i].k == 2'h0)
        pulse_start(10'h003);
      else
        @(posedge sys_clk);
      {sw, wd} <= 2'h0;
      wait_rst();
      ecfg = rows[i].k == 2'h0 ? rows[i].c : {ecfg[15:13], rows[i].c[12:8], 6'h3f, ecfg[1:0]};
      chk(n, 522);
      chk({oe_seen, bad, hc_seen}, {rows[i].o, 2'b01});
      chk(ab_seen, rows[i].k != 2'h2);
      chk({lcfg, fa}, {ecfg, 24'h00_0000});
      bus(1'b0, 4'h4, 32'h0000_0000);
      chk(q, rows[i].f);
      bus(1'b0, 4'h0, 32'h0000_0000);
      chk({q, rout_n}, 33'h0);
      mode_low <= 1'b0;
      $display("Row %0d test done", i);
    end
    end_init();
    bus(1'b1, 4'h0, 32'h0000_0008);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    pulse_start(10'h258);
    wait_rst();
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk({q, tr_seen, tr}, {32'h0000_0018, 2'b10});
    $display("Long reset test done");
    {xact, xrdy} <= 2'b11;
    wd <= 1'b1;
    @(posedge sys_clk);
    wd <= 1'b0;
    wait_rst();
    {xact, xrdy} <= 2'b00;
    chk({n, ab_seen, hc_seen}, {32'h0000_020a, 2'b11});
    $display("Watchdog abort test done");
    pulse_start(10'h014);
    repeat (14) @(posedge sys_clk);
    mode_low <= 1'b1;
    boot_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(pu, 1'b1);
    mode_low <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(irst_n, 1'b0);
    fl_rdy <= 1'b1;
    wait_rst();
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    $display("Async and flash test done");
    report_and_stop();
  end
endmodule : test_system_reset_sequencer
